// file: rtl/afe_parallel_iq_data_port.sv
// Purpose: Digital data port of a dual receive / dual transmit converter front end
// Assumes: The converter clock is modelled as alternating clk phases (rise, fall)
// Notes: Transmit outputs and settings are register outputs to the analog side
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Both receive channels are sampled together at the rising converter edge.
// - The shared receive bus carries in-phase after rising and quadrature after falling edges.
// - In-phase data appears 5 cycles and quadrature data 5.5 cycles after sampling.
// - The receive converter is a seven-stage pipeline stepping every half cycle.
// - Receive words are 10-bit offset binary with 512 as bipolar zero.
// - The receive bus is released in off, idle, hold, transmit-only and both receive-off states.
// - In-phase transmit is captured at the falling edge, quadrature at the next rising edge.
// - Both transmit outputs update together when the quadrature word is captured.
// - The transmit full scale is selectable between two output settings.
// - Each transmit channel has its own offset trim setting.
// - Receive and transmit buses can each be disabled on their own.
// - One control bit selects the transmit full-scale setting.
// - Each offset trim is held in its own 6-bit register.
module afe_parallel_iq_data_port
  import afe_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iq_pair_t rxAnalog,
  output logic [SAMPLE_W-1:0] rxSampleBusOut,
  output logic rxSampleBusOe,
  output logic rxSampleIsQuad,
  output logic convPhaseRise,
  input wire logic [SAMPLE_W-1:0] txSampleBus,
  output iq_pair_t txOut,
  output logic txFullscaleSelect,
  output logic [TRIM_W-1:0] txInphaseTrim,
  output logic [TRIM_W-1:0] txQuadTrim
);
  // Converter phase
  phase_t phase_q, phase_d;
  // Register file
  logic [31:0] ctrl_q, ctrl_d;
  logic [TRIM_W-1:0] iTrim_q, iTrim_d, qTrim_q, qTrim_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  // Receive path
  rx_bus_t rxBus_q, rxBus_d;
  iq_pair_t histRd;
  logic [3:0] histIdx;
  logic [3:0] fill_q, fill_d;
  // Transmit path
  logic [SAMPLE_W-1:0] txIHold_q, txIHold_d;
  iq_pair_t txOut_q, txOut_d;

  pwr_mode_t mode;
  logic rxOn, txOn, apbAccess;

  assign mode = pwr_mode_t'(ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W]);
  assign rxOn = rxPathOn(mode, ctrl_q[CTRL_RXEN_BIT]);
  assign txOn = txPathOn(mode, ctrl_q[CTRL_TXEN_BIT]);
  assign apbAccess = psel && penable;

  always_comb
  begin
    case (phase_q)
      PH_RISE: phase_d = PH_FALL;
      PH_FALL: phase_d = PH_RISE;
      default: phase_d = PH_RISE;
    endcase
  end

  // APB slave: one wait-free access phase, unmapped reads zero with error
  always_comb
  begin
    ctrl_d = ctrl_q;
    iTrim_d = iTrim_q;
    qTrim_d = qTrim_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (paddr)
        OFS_CTRL:
        begin
          prdata_d = ctrl_q;
          if (pwrite)
          begin
            ctrl_d = pwdata & 32'h0000_0387;
          end
        end
        OFS_ITRIM:
        begin
          prdata_d = {26'h0, iTrim_q};
          if (pwrite)
          begin
            iTrim_d = pwdata[TRIM_W-1:0];
          end
        end
        OFS_QTRIM:
        begin
          prdata_d = {26'h0, qTrim_q};
          if (pwrite)
          begin
            qTrim_d = pwdata[TRIM_W-1:0];
          end
        end
        OFS_STATUS: prdata_d = {28'h0, fill_q == 4'(LAT_Q_HALF), txOn, rxOn, rxBus_q.oe};
        OFS_RXLAST: prdata_d = {22'h0, rxBus_q.data};
        default: pslverr_d = 1'b1;
      endcase
      if (!pwrite)
      begin
        ctrl_d = ctrl_q;
      end
    end
  end

  // Writes commit in the access phase so they land at the pready edge
  logic [31:0] ctrlCommit;
  logic [TRIM_W-1:0] iCommit, qCommit;
  logic [31:0] ctrlPend_q;
  logic [TRIM_W-1:0] iPend_q, qPend_q;
  always_comb
  begin
    ctrlCommit = ctrl_q;
    iCommit = iTrim_q;
    qCommit = qTrim_q;
    if (apbAccess && pready_q && pwrite && !pslverr_q)
    begin
      ctrlCommit = ctrlPend_q;
      iCommit = iPend_q;
      qCommit = qPend_q;
    end
  end

  // Receive: in-phase read at 10 half-cycles, quadrature at 11, both from one sample
  always_comb
  begin
    fill_d = fill_q;
    if (!rxOn)
    begin
      fill_d = 4'h0;
    end
    else if (fill_q != 4'(LAT_Q_HALF))
    begin
      fill_d = fill_q + 4'h1;
    end
    histIdx = (phase_q == PH_FALL) ? 4'(LAT_I_HALF - 2) : 4'(LAT_Q_HALF - 2);
    rxBus_d = rxBus_q;
    rxBus_d.oe = rxOn && (fill_q == 4'(LAT_Q_HALF));
    // Registered bus: a word chosen in a rise half shows in the half after the rising edge
    if (phase_q == PH_RISE)
    begin
      rxBus_d.data = histRd.inphase;
      rxBus_d.isQuad = 1'b0;
    end
    else
    begin
      rxBus_d.data = histRd.quad;
      rxBus_d.isQuad = 1'b1;
    end
  end

  // Sample both channels on the rising phase only; history advances each half-cycle
  iq_pair_t sampleIn;
  logic [SAMPLE_W-1:0] iSampled_q, qSampled_q;
  assign sampleIn = (phase_q == PH_RISE) ? rxAnalog : iq_pair_t'{inphase: iSampled_q,
    quad: qSampled_q};

  sample_history u_hist
  (
    .clk(clk),
    .reset(reset),
    .shift(1'b1),
    .wrData(sampleIn),
    .rdIndex(histIdx),
    .rdData(histRd)
  );

  // Transmit capture
  always_comb
  begin
    txIHold_d = txIHold_q;
    txOut_d = txOut_q;
    if (!txOn)
    begin
      txOut_d = '{inphase: MID_CODE, quad: MID_CODE};
    end
    else if (phase_q == PH_FALL)
    begin
      txIHold_d = txSampleBus;
    end
    else
    begin
      txOut_d = '{inphase: txIHold_q, quad: txSampleBus};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      phase_q <= PH_RISE;
      ctrl_q <= CTRL_RESET;
      iTrim_q <= TRIM_RESET;
      qTrim_q <= TRIM_RESET;
      ctrlPend_q <= CTRL_RESET;
      iPend_q <= TRIM_RESET;
      qPend_q <= TRIM_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rxBus_q <= '{data: MID_CODE, oe: 1'b0, isQuad: 1'b0};
      fill_q <= 4'h0;
      iSampled_q <= MID_CODE;
      qSampled_q <= MID_CODE;
      txIHold_q <= MID_CODE;
      txOut_q <= '{inphase: MID_CODE, quad: MID_CODE};
    end
    else
    begin
      phase_q <= phase_d;
      ctrl_q <= ctrlCommit;
      iTrim_q <= iCommit;
      qTrim_q <= qCommit;
      ctrlPend_q <= ctrl_d;
      iPend_q <= iTrim_d;
      qPend_q <= qTrim_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      rxBus_q <= rxBus_d;
      fill_q <= fill_d;
      iSampled_q <= sampleIn.inphase;
      qSampled_q <= sampleIn.quad;
      txIHold_q <= txIHold_d;
      txOut_q <= txOut_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rxSampleBusOut = rxBus_q.data;
  assign rxSampleBusOe = rxBus_q.oe;
  assign rxSampleIsQuad = rxBus_q.isQuad;
  assign convPhaseRise = phase_q[1]; // Fall code bit: high in the cycle after a rise
  assign txOut = txOut_q;
  assign txFullscaleSelect = ctrl_q[CTRL_FS_BIT];
  assign txInphaseTrim = iTrim_q;
  assign txQuadTrim = qTrim_q;

  // Checks
  a_rx_off_release: assert property (@(posedge clk) disable iff (reset)
    !rxOn |=> !rxSampleBusOe) else $error("rx bus driven while off");
  a_rx_phase_tag: assert property (@(posedge clk) disable iff (reset)
    rxSampleBusOe |-> rxSampleIsQuad == !convPhaseRise) else $error("rx tag wrong");
  // Sampled at the edge closing a rise cycle; words are launched 10 and 11 edges later
  a_rx_i_latency: assert property (@(posedge clk) disable iff (reset)
    (phase_q == PH_RISE && rxOn) ##11 (rxOn && rxSampleBusOe && !rxSampleIsQuad)
    |-> rxSampleBusOut == $past(rxAnalog.inphase, 11)) else $error("I latency");
  a_rx_q_latency: assert property (@(posedge clk) disable iff (reset)
    (phase_q == PH_RISE && rxOn) ##12 (rxOn && rxSampleBusOe && rxSampleIsQuad)
    |-> rxSampleBusOut == $past(rxAnalog.quad, 12)) else $error("Q latency");
  a_tx_pair_update: assert property (@(posedge clk) disable iff (reset)
    (txOn && phase_q == PH_FALL) ##1 (txOn && phase_q == PH_RISE) |=>
    txOut.inphase == $past(txSampleBus, 2) && txOut.quad == $past(txSampleBus))
    else $error("tx pair");
  a_tx_hold_fall: assert property (@(posedge clk) disable iff (reset)
    (txOn && phase_q == PH_FALL) |=> $stable(txOut)) else $error("tx moved");
  a_trim_write: assert property (@(posedge clk) disable iff (reset)
    (apbAccess && pready && pwrite && paddr == OFS_ITRIM) |=>
    txInphaseTrim == $past(pwdata[TRIM_W-1:0])) else $error("trim write");
  a_fs_write: assert property (@(posedge clk) disable iff (reset)
    (apbAccess && pready && pwrite && paddr == OFS_CTRL) |=>
    txFullscaleSelect == $past(pwdata[CTRL_FS_BIT])) else $error("fs write");
  a_apb_answer: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable) |=> pready) else $error("no answer");
  // A disabled transmit path parks both outputs at mid code
  a_tx_off_mid: assert property (@(posedge clk) disable iff (reset)
    !txOn |=> txOut == {MID_CODE, MID_CODE}) else $error("tx not parked");
  c_rx_live: cover property (@(posedge clk) rxSampleBusOe && rxSampleIsQuad);
  c_rx_inphase: cover property (@(posedge clk) rxSampleBusOe && !rxSampleIsQuad);
  c_tx_update: cover property (@(posedge clk) txOn && phase_q == PH_RISE);
  c_fs_high: cover property (@(posedge clk) txFullscaleSelect);
endmodule // afe_parallel_iq_data_port
`default_nettype wire

// file: rtl/afe_port_pkg.sv
// Purpose: Shared constants and carriers for the converter data port
// Assumes: One 200 MHz clock; the converter half-clock is modelled in clk phases
// Notes: Register offsets are APB byte addresses
package afe_port_pkg;
  localparam int unsigned SAMPLE_W = 10;
  localparam int unsigned TRIM_W = 6;
  localparam int unsigned PIPE_STAGES = 7;
  // Pipeline delays in half-cycles of the converter clock
  localparam int unsigned LAT_I_HALF = 10;
  localparam int unsigned LAT_Q_HALF = 11;
  localparam int unsigned HIST_DEPTH = 12;
  localparam logic [SAMPLE_W-1:0] MID_CODE = 10'h200;
  localparam logic [SAMPLE_W-1:0] MAX_CODE = 10'h3ff;
  localparam logic [SAMPLE_W-1:0] MIN_CODE = 10'h000;
  // APB map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ITRIM = 8'h04;
  localparam logic [7:0] OFS_QTRIM = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RXLAST = 8'h10;
  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_MODE_W = 3;
  localparam int unsigned CTRL_FS_BIT = 7;
  localparam int unsigned CTRL_RXEN_BIT = 8;
  localparam int unsigned CTRL_TXEN_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;

  typedef enum logic [2:0]
  {
    PM_FULL_OFF = 3'h0,
    PM_IDLE = 3'h1,
    PM_LOW_POWER_HOLD = 3'h2,
    PM_RX_OFF_A = 3'h3,
    PM_RX_OFF_B = 3'h4,
    PM_FULL_DUPLEX = 3'h5,
    PM_RX_ONLY = 3'h6,
    PM_TX_ONLY = 3'h7
  } pwr_mode_t;

  typedef enum logic [1:0]
  {
    PH_RISE = 2'b01,
    PH_FALL = 2'b10
  } phase_t;

  typedef struct packed
  {
    logic [SAMPLE_W-1:0] inphase;
    logic [SAMPLE_W-1:0] quad;
  } iq_pair_t;

  typedef struct packed
  {
    logic [SAMPLE_W-1:0] data;
    logic oe;
    logic isQuad;
  } rx_bus_t;

  function automatic logic rxPathOn(input pwr_mode_t m, input logic en);
    rxPathOn = en && (m == PM_FULL_DUPLEX || m == PM_RX_ONLY);
  endfunction

  function automatic logic txPathOn(input pwr_mode_t m, input logic en);
    txPathOn = en && (m == PM_FULL_DUPLEX || m == PM_TX_ONLY || m == PM_RX_OFF_A
      || m == PM_RX_OFF_B);
  endfunction
endpackage

// file: rtl/sample_history.sv
// Purpose: Shift memory that holds the receive pipeline history
// Assumes: One shift per converter half-cycle
// Notes: Read data come out of a register
`timescale 1ns/10ps
`default_nettype none
module sample_history
  import afe_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic shift,
  input wire iq_pair_t wrData,
  input wire logic [3:0] rdIndex,
  output iq_pair_t rdData
);
  iq_pair_t mem_q [HIST_DEPTH];
  iq_pair_t mem_d [HIST_DEPTH];
  iq_pair_t rd_q;
  iq_pair_t rd_d;

  always_comb
  begin
    for (int i = 0; i < HIST_DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
    end
    if (shift)
    begin
      mem_d[0] = wrData;
      for (int i = 1; i < HIST_DEPTH; i++)
      begin
        mem_d[i] = mem_q[i-1];
      end
    end
    rd_d = mem_q[rdIndex];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < HIST_DEPTH; i++)
      begin
        mem_q[i] <= '{inphase: MID_CODE, quad: MID_CODE};
      end
      rd_q <= '{inphase: MID_CODE, quad: MID_CODE};
    end
    else
    begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign rdData = rd_q;
endmodule // sample_history
`default_nettype wire

// file: bench/baseband_model.sv
// Purpose: Baseband processor model facing the converter data port
// Assumes: convPhaseRise marks the clk cycles of a modelled rising converter edge
// Notes: Converter half-clocks are clk phases, so the model never outruns the converter rate
`timescale 1ns/10ps
`default_nettype none
module baseband_model
  import afe_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic convPhaseRise,
  input wire logic [SAMPLE_W-1:0] txI,
  input wire logic [SAMPLE_W-1:0] txQ,
  output logic [SAMPLE_W-1:0] txSampleBus,
  output logic rxTagQuad
);
  logic [SAMPLE_W-1:0] txBus_d;
  logic [SAMPLE_W-1:0] txBus_q;

  // Flag low marks a rise half; the registered word lands in the next, falling half,
  // which must carry the in-phase word
  always_comb
  begin
    txBus_d = convPhaseRise ? txQ : txI;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      txBus_q <= MID_CODE;
    else
      txBus_q <= txBus_d;
  end

  assign txSampleBus = txBus_q;
  // The clock phase alone tells which channel a receive word belongs to
  assign rxTagQuad = !convPhaseRise;
endmodule // baseband_model
`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench for the converter data port
// Assumes: APB answers in the access phase; first cycle after reset is a rise phase
// Notes: Receive words are checked every cycle against a history of the converter inputs
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import afe_port_pkg::*;
  logic clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  iq_pair_t rxAnalog;
  logic [SAMPLE_W-1:0] rxBus;
  logic rxOe;
  logic rxIsQuad;
  logic phaseRise;
  logic [SAMPLE_W-1:0] txBus;
  iq_pair_t txOut;
  logic fsSel;
  logic [TRIM_W-1:0] iTrim;
  logic [TRIM_W-1:0] qTrim;
  logic [SAMPLE_W-1:0] txI;
  logic [SAMPLE_W-1:0] txQ;
  logic tagQuad;
  logic txMon;
  logic rxOn;
  logic txOn;
  iq_pair_t prevTx;
  iq_pair_t hist [0:12];
  logic [19:0] pairs [0:3];
  logic [31:0] rd;
  logic err;
  int err_count;
  int check_count;

  afe_parallel_iq_data_port DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxAnalog(rxAnalog), .rxSampleBusOut(rxBus), .rxSampleBusOe(rxOe),
    .rxSampleIsQuad(rxIsQuad), .convPhaseRise(phaseRise), .txSampleBus(txBus), .txOut(txOut),
    .txFullscaleSelect(fsSel), .txInphaseTrim(iTrim), .txQuadTrim(qTrim));

  baseband_model host (.clk(clk), .reset(reset), .convPhaseRise(phaseRise), .txI(txI),
    .txQ(txQ), .txSampleBus(txBus), .rxTagQuad(tagQuad));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Holds the request until pready is seen high; no fixed wait is assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk(32'h0, 32'h1, "apb timeout");
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Inputs change every cycle, so a wrong sampling phase or delay shows at once
  always @(posedge clk)
  begin
    for (int i = 12; i > 0; i--)
      hist[i] = hist[i-1];
    hist[0] = rxAnalog;
    // hist[k] was sampled k edges ago; I is launched 10 edges after it, Q 11
    if (!reset && rxOe === 1'b1)
    begin
      chk({31'h0, rxIsQuad}, {31'h0, tagQuad}, "rx channel tag");
      if (tagQuad)
        chk({22'h0, rxBus}, {22'h0, hist[12].quad}, "rx quad");
      else
        chk({22'h0, rxBus}, {22'h0, hist[11].inphase}, "rx inphase");
    end
    if (txMon && txOut !== prevTx)
      chk({31'h0, phaseRise}, 32'h1, "tx update phase");
    prevTx = txOut;
    if (reset)
      rxAnalog <= {MID_CODE, MAX_CODE};
    else
      rxAnalog <= {rxAnalog.inphase + 10'h1, rxAnalog.quad - 10'h3};
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    txI = MID_CODE;
    txQ = MID_CODE;
    txMon = 1'b0;
    err_count = 0;
    check_count = 0;
    pairs = '{20'h003ff, 20'hffc00, 20'h801ff, 20'h7fe01};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    chk({12'h0, txOut}, {12'h0, MID_CODE, MID_CODE}, "tx off at reset");
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0, "ignored write");
    apb(1'b1, OFS_ITRIM, 32'hffff_ffff);
    apb(1'b1, OFS_QTRIM, 32'h0000_002a);
    apb(1'b0, OFS_ITRIM, 32'h0);
    chk(rd, 32'h0000_003f, "itrim width");
    apb(1'b0, OFS_QTRIM, 32'h0);
    chk(rd, 32'h0000_002a, "qtrim value");
    chk({20'h0, iTrim, qTrim}, 32'h0000_0fea, "trim outputs");
    apb(1'b1, OFS_CTRL, 32'hffff_ffff);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_0387, "ctrl fields");
    for (int m = 0; m < 8; m++)
    begin
      txI <= 10'h3ff - 10'(m);
      txQ <= 10'(m);
      apb(1'b1, OFS_CTRL, 32'h300 | (32'(m % 2) << 7) | 32'(m));
      repeat (16) @(posedge clk);
      rxOn = (m == 5 || m == 6);
      txOn = (m >= 3 && m != 6);
      chk({31'h0, rxOe}, 32'(rxOn), "rx bus release");
      chk({12'h0, txOut}, txOn ? {12'h0, 10'h3ff - 10'(m), 10'(m)} :
        {12'h0, MID_CODE, MID_CODE}, "tx path");
      chk({31'h0, fsSel}, 32'(m % 2), "fullscale select");
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({29'h0, rd[2:0]}, {29'h0, txOn, rxOn, rxOn}, "status");
    end
    apb(1'b1, OFS_CTRL, 32'h205);
    repeat (16) @(posedge clk);
    chk({11'h0, rxOe, txOut}, {12'h0, 10'h3f8, 10'h007}, "rx off tx on");
    apb(1'b1, OFS_CTRL, 32'h105);
    repeat (16) @(posedge clk);
    chk({11'h0, rxOe, txOut}, {12'h1, MID_CODE, MID_CODE}, "tx off rx on");
    apb(1'b1, OFS_CTRL, 32'h207);
    repeat (8) @(posedge clk);
    txMon <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      {txI, txQ} <= pairs[i];
      repeat (6) @(posedge clk);
      chk({12'h0, txOut}, {12'h0, pairs[i]}, "tx pair");
    end
    txMon <= 1'b0;
    conclude();
  end
endmodule // testbench
`default_nettype wire
